/* File: rtl/iavg_consts.vh */
// Constants for the interrupt acknowledge vector generator
`ifndef IAVG_CONSTS_VH
`define IAVG_CONSTS_VH
`define IAVG_CALL_OPCODE    8'hCD
`define IAVG_LEVEL_DEFAULT  3'h7
`define IAVG_ZERO2          2'h0
`define IAVG_ZERO3          3'h0
`define IAVG_ZERO8          8'h00
`define IAVG_MODE_8BIT      1'b0
`define IAVG_MODE_16BIT     1'b1
`define IAVG_INTERVAL_4     1'b1
`define IAVG_SEL_DEF        4'h1
`define IAVG_SEL_FIRST      4'h1
`define IAVG_SEL_SECOND     4'h2
`define IAVG_SEL_THIRD      4'h4
`define IAVG_SEL_DONE       4'h8
`define IAVG_BUS_OFF_N      8'hFF
`define IAVG_BUS_ON_N       8'h00
`endif

/* File: rtl/iavg_vector_gen.v */
// Interrupt acknowledge vector byte generator, one clock domain
// Overview of operation
// - 8-bit mode: CALL opcode on pulse one
// - 8-bit mode: low address byte on pulse two
// - Interval 4: addr 7:5, level 4:2, zeros
// - Interval 8: addr 7:6, level 5:3, zeros
// - 8-bit mode: high address byte on pulse three
// - 16-bit mode: two cycles, never a CALL
// - First pulse freezes status, resolves level
// - Cascade master: slave id after pulse one, if that level has a slave
// - 16-bit mode: bus released during cycle one
// - 16-bit mode: one vector byte, cycle two
// - 16-bit mode ignores interval and address
// - Vector: type bits 7:3, level 2:0
// - Vanished request gives level seven
// - Interval select 1 means 4, 0 means 8
// - Mode bit 0 CALL, 1 type byte
`include "iavg_consts.vh"

module iavg_vector_gen (
  input  wire       clk_sys,
  input  wire       resetn,
  input  wire       irq_ack_strobe_n,   // From processor pin
  input  wire       cpu_mode_sel,       // 0 CALL sequence, 1 type byte
  input  wire       call_interval_sel,  // 1 interval 4, 0 interval 8
  input  wire [2:0] routine_addr_low,   // Programmed address bits 7:5
  input  wire [7:0] routine_addr_high,  // Programmed address bits 15:8
  input  wire [4:0] vector_type_high,   // Programmed type bits 7:3
  input  wire       req_valid,          // Resolver has a winning level
  input  wire [2:0] req_level,          // Level picked by resolver
  input  wire       cascade_master,     // This controller is master
  input  wire [7:0] slave_present,      // Slave attached per level
  output reg  [7:0] data_out,           // Byte put on the data bus
  output reg  [7:0] data_oe_n,          // Low while bus is driven
  output reg  [2:0] cascade_id,         // Slave id to cascade lines
  output reg        cascade_oe_n,       // Low while id is driven
  output reg        level_frozen,       // Pulse: level latched
  output reg  [2:0] frozen_level,       // Level of this sequence
  output wire       seq_busy            // Sequence in progress
);

  // Synchroniser for the acknowledge pin; stage one read only by two
  reg       ack_meta_reg;
  reg       ack_sync_reg;
  reg       ack_prev_reg;   // Previous synced level, for edges
  reg [3:0] sel_reg;        // One-hot byte selector
  reg [3:0] sel_next;
  reg       mode_reg;       // Mode held for the whole sequence
  reg       mode_next;
  reg [2:0] level_reg;
  reg [2:0] level_next;
  reg       master_id_reg;  // Cascade id is valid for this sequence
  reg       master_id_next;

  // One-hot byte selector states
  localparam [3:0] ST_FIRST  = `IAVG_SEL_FIRST;   // Waiting for pulse one
  localparam [3:0] ST_SECOND = `IAVG_SEL_SECOND;  // Waiting for pulse two
  localparam [3:0] ST_THIRD  = `IAVG_SEL_THIRD;   // CALL byte three next

  // Strobe edges; all three flops reset to the idle level of the pin,
  // so no false fall is seen right after reset
  wire ack_fall = ack_prev_reg & ~ack_sync_reg;
  wire ack_rise = ~ack_prev_reg & ack_sync_reg;

  // Low address byte for the two routine intervals
  function [7:0] iavg_low_byte;
    input       interval4;
    input [2:0] addr;
    input [2:0] lvl;
    begin
      if (interval4 == `IAVG_INTERVAL_4) begin
        iavg_low_byte = {addr, lvl, `IAVG_ZERO2};
      end else begin
        iavg_low_byte = {addr[2:1], lvl, `IAVG_ZERO3};
      end
    end
  endfunction

  assign seq_busy = (sel_reg != ST_FIRST);

  // Two-stage synchroniser; pin idles high so reset to one
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ack_meta_reg <= 1'b1;
      ack_sync_reg <= 1'b1;
      ack_prev_reg <= 1'b1;
    end else begin
      ack_meta_reg <= irq_ack_strobe_n;
      ack_sync_reg <= ack_meta_reg;
      ack_prev_reg <= ack_sync_reg;
    end
  end

  // Selector advances on each pulse's rising edge; the fall of pulse
  // one freezes mode and level, so a resolver change in mid-sequence
  // cannot split one vector across two levels
  always @* begin
    sel_next       = sel_reg;
    mode_next      = mode_reg;
    level_next     = level_reg;
    master_id_next = master_id_reg;
    case (sel_reg)
      ST_FIRST: begin
        if (ack_fall) begin
          // Freeze mode and level for the sequence
          mode_next = cpu_mode_sel;
          if (req_valid) begin
            level_next = req_level;
          end else begin
            // Request gone before pulse one: fall back to seven
            level_next = `IAVG_LEVEL_DEFAULT;
          end
        end
        if (ack_rise) begin
          sel_next = ST_SECOND;
          // Master with a slave on this level presents id once pulse one ends
          master_id_next = cascade_master & slave_present[level_reg];
        end
      end
      ST_SECOND: begin
        if (ack_rise) begin
          // 16-bit mode ends after two cycles
          if (mode_reg == `IAVG_MODE_16BIT) begin
            sel_next       = ST_FIRST;
            master_id_next = 1'b0;
          end else begin
            sel_next = ST_THIRD;
          end
        end
      end
      ST_THIRD: begin
        if (ack_rise) begin
          // Third pulse closes the CALL sequence
          sel_next       = ST_FIRST;
          master_id_next = 1'b0;
        end
      end
      default: begin
        // Stray selector code: recover to the first position
        sel_next       = `IAVG_SEL_DEF;
        master_id_next = 1'b0;
      end
    endcase
  end

  // Sequence state registers
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sel_reg       <= `IAVG_SEL_DEF;
      mode_reg      <= `IAVG_MODE_8BIT;
      level_reg     <= `IAVG_LEVEL_DEFAULT;
      master_id_reg <= 1'b0;
    end else begin
      sel_reg       <= sel_next;
      mode_reg      <= mode_next;
      level_reg     <= level_next;
      master_id_reg <= master_id_next;
    end
  end

  // Data bus drive: registered, only while a byte pulse is low
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      data_out  <= `IAVG_ZERO8;
      data_oe_n <= `IAVG_BUS_OFF_N;
    end else if (ack_sync_reg) begin
      // Strobe high: bus released
      data_out  <= `IAVG_ZERO8;
      data_oe_n <= `IAVG_BUS_OFF_N;
    end else begin
      data_oe_n <= `IAVG_BUS_ON_N;
      case (sel_reg)
        ST_FIRST: begin
          // Mode as frozen; on the freezing edge the new value itself
          if (mode_next == `IAVG_MODE_16BIT) begin
            // No data in first cycle, never a CALL
            data_out  <= `IAVG_ZERO8;
            data_oe_n <= `IAVG_BUS_OFF_N;
          end else begin
            data_out <= `IAVG_CALL_OPCODE;
          end
        end
        ST_SECOND: begin
          if (mode_reg == `IAVG_MODE_16BIT) begin
            // Type byte; interval and address unused
            data_out <= {vector_type_high, level_reg};
          end else begin
            data_out <= iavg_low_byte(call_interval_sel,
                                      routine_addr_low,
                                      level_reg);
          end
        end
        ST_THIRD: begin
          data_out <= routine_addr_high;
        end
        default: begin
          data_out  <= `IAVG_ZERO8;
          data_oe_n <= `IAVG_BUS_OFF_N;
        end
      endcase
    end
  end

  // Cascade id and freeze report outputs; the id is cleared with the
  // last pulse so a master never leaves stale lines driven
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cascade_id   <= `IAVG_ZERO3;
      cascade_oe_n <= 1'b1;
      level_frozen <= 1'b0;
      frozen_level <= `IAVG_LEVEL_DEFAULT;
    end else begin
      cascade_id   <= master_id_next ? level_next : `IAVG_ZERO3;
      cascade_oe_n <= ~master_id_next;
      level_frozen <= (sel_reg == ST_FIRST) & ack_fall;
      frozen_level <= level_next;
    end
  end

endmodule

/* File: sim/iavg_chk.sv */
// Port checker for the acknowledge vector generator
module iavg_chk (
  input wire       clk_sys,
  input wire       resetn,
  input wire       irq_ack_strobe_n,
  input wire       cpu_mode_sel,
  input wire       req_valid,
  input wire [2:0] req_level,
  input wire [7:0] data_out,
  input wire [7:0] data_oe_n,
  input wire [2:0] cascade_id,
  input wire       cascade_oe_n,
  input wire       level_frozen,
  input wire [2:0] frozen_level
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  property p_oe; data_oe_n == 8'h00 || data_oe_n == 8'hFF; endproperty
  a_oe: assert property (p_oe) else $error("split enable");
  // Four high samples cover the two-flop sync plus the output register
  property p_idle; irq_ack_strobe_n [*4] |-> data_oe_n == 8'hFF; endproperty
  a_idle: assert property (p_idle) else $error("bus driven idle");
  property p_zero; data_oe_n == 8'hFF |-> data_out == 8'h00; endproperty
  a_zero: assert property (p_zero) else $error("data while off");
  property p_call;
    level_frozen && !cpu_mode_sel |-> data_out == 8'hCD && !data_oe_n[0];
  endproperty
  a_call: assert property (p_call) else $error("no call byte");
  property p_q16; level_frozen && cpu_mode_sel |-> data_oe_n[0]; endproperty
  a_q16: assert property (p_q16) else $error("cycle one driven");
  property p_pls; level_frozen |=> !level_frozen; endproperty
  a_pls: assert property (p_pls) else $error("freeze too long");
  // Inputs are held steady by the bench across a sequence
  property p_lvl;
    level_frozen |=> frozen_level == (req_valid ? req_level : 3'h7);
  endproperty
  a_lvl: assert property (p_lvl) else $error("wrong level");
  property p_cas; !cascade_oe_n |-> cascade_id == frozen_level; endproperty
  a_cas: assert property (p_cas) else $error("wrong slave id");
  c_8: cover property (level_frozen && !cpu_mode_sel);
  c_16: cover property (level_frozen && cpu_mode_sel);
  c_cas: cover property (!cascade_oe_n);
  c_v7: cover property (level_frozen && !req_valid);
endmodule
bind iavg_vector_gen iavg_chk iavg_chk_inst (
  .clk_sys          (clk_sys),
  .resetn           (resetn),
  .irq_ack_strobe_n (irq_ack_strobe_n),
  .cpu_mode_sel     (cpu_mode_sel),
  .req_valid        (req_valid),
  .req_level        (req_level),
  .data_out         (data_out),
  .data_oe_n        (data_oe_n),
  .cascade_id       (cascade_id),
  .cascade_oe_n     (cascade_oe_n),
  .level_frozen     (level_frozen),
  .frozen_level     (frozen_level)
);

/* File: sim/iavg_cpu_model.sv */
// Processor side that issues acknowledge pulses
module iavg_cpu_model (
  input  wire       clk_sys,
  output logic      irq_ack_strobe_n,
  input  wire [7:0] data_out,
  input  wire [7:0] data_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial irq_ack_strobe_n = 1'b1;  // Pin must be high at release
  // Five low, five high: slow enough for the synchroniser
  task automatic pulse(output logic [7:0] d, output logic [7:0] o);
    @(negedge clk_sys) irq_ack_strobe_n = 1'b0;
    repeat (5) @(negedge clk_sys);
    d = data_out;
    o = data_oe_n;
    irq_ack_strobe_n = 1'b1;
    repeat (5) @(negedge clk_sys);
  endtask
endmodule

/* File: sim/iavg_vector_gen_tb.sv */
// Self-checking bench for the acknowledge vector generator
module iavg_vector_gen_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_sys = 1'b0;
  logic       resetn = 1'b0;
  logic       cpu_mode_sel = 1'b0;
  logic       call_interval_sel = 1'b0;
  logic       req_valid = 1'b0;
  logic [2:0] req_level = 3'h0;
  logic [2:0] routine_addr_low = 3'h5;
  logic [7:0] routine_addr_high = 8'hA5;
  logic [4:0] vector_type_high = 5'h15;
  logic       cascade_master = 1'b1;  // Master, a slave on every level
  logic [7:0] slave_present = 8'hFF;
  wire        irq_ack_strobe_n, cascade_oe_n, level_frozen, seq_busy;
  wire  [7:0] data_out, data_oe_n;
  wire  [2:0] cascade_id, frozen_level;
  int         bad_count = 0;
  int         checks_done = 0;
  int         cycles = 0;
  logic [7:0] d0, o0;                 // Pulse taken before mid-run reset
  always #5 clk_sys = ~clk_sys;
  iavg_vector_gen iavg_vector_gen_inst (
    .clk_sys           (clk_sys),
    .resetn            (resetn),
    .irq_ack_strobe_n  (irq_ack_strobe_n),
    .cpu_mode_sel      (cpu_mode_sel),
    .call_interval_sel (call_interval_sel),
    .routine_addr_low  (routine_addr_low),
    .routine_addr_high (routine_addr_high),
    .vector_type_high  (vector_type_high),
    .req_valid         (req_valid),
    .req_level         (req_level),
    .cascade_master    (cascade_master),
    .slave_present     (slave_present),
    .data_out          (data_out),
    .data_oe_n         (data_oe_n),
    .cascade_id        (cascade_id),
    .cascade_oe_n      (cascade_oe_n),
    .level_frozen      (level_frozen),
    .frozen_level      (frozen_level),
    .seq_busy          (seq_busy)
  );
  iavg_cpu_model iavg_cpu_model_inst (
    .clk_sys          (clk_sys),
    .irq_ack_strobe_n (irq_ack_strobe_n),
    .data_out         (data_out),
    .data_oe_n        (data_oe_n)
  );
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // One acknowledge sequence; inputs change only while idle
  task automatic seq(input logic m, i, v, input logic [2:0] l,
                     input logic [7:0] b1, b2, b3);
    logic [7:0]  d, o;
    logic [2:0]  lv;
    logic [15:0] e;
    @(negedge clk_sys);
    {cpu_mode_sel, call_interval_sel, req_valid, req_level} = {m, i, v, l};
    // Busy after pulse one; id only from a master with that slave
    lv = v ? l : 3'h7;
    e = {11'h000, 1'b1, 1'b1, 3'h0};
    if (cascade_master && slave_present[lv]) e[3:0] = {1'b0, lv};
    iavg_cpu_model_inst.pulse(d, o);
    if (m) chk({d, o}, 16'h00FF);
    else chk({o, d}, {8'h00, b1});
    chk({11'h000, seq_busy, cascade_oe_n, cascade_id}, e);
    iavg_cpu_model_inst.pulse(d, o);
    chk({o, d}, {8'h00, b2});
    if (!m) begin
      iavg_cpu_model_inst.pulse(d, o);
      chk({o, d}, {8'h00, b3});
    end
    chk({6'h00, seq_busy, cascade_oe_n, data_oe_n}, 16'h01FF);
  endtask
  // Hang guard, far above the about 164 cycles needed
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 1000) begin
      bad_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (4) @(negedge clk_sys);
    resetn = 1'b1;
    chk({data_oe_n, data_out}, 16'hFF00);
    seq(1'b0, 1'b0, 1'b1, 3'h5, 8'hCD, 8'hA8, 8'hA5);
    seq(1'b0, 1'b1, 1'b1, 3'h3, 8'hCD, 8'hAC, 8'hA5);
    // Reset after pulse one must send the selector home
    iavg_cpu_model_inst.pulse(d0, o0);
    chk({o0, d0}, 16'h00CD);
    resetn = 1'b0;
    @(negedge clk_sys);
    chk({6'h00, seq_busy, cascade_oe_n, data_oe_n}, 16'h01FF);
    resetn = 1'b1;
    seq(1'b1, 1'b1, 1'b1, 3'h2, 8'h00, 8'hAA, 8'h00);
    slave_present = 8'h7F;  // No slave behind level seven
    seq(1'b1, 1'b0, 1'b0, 3'h1, 8'h00, 8'hAF, 8'h00);
    cascade_master = 1'b0;  // Lone controller drives no id
    seq(1'b0, 1'b1, 1'b1, 3'h0, 8'hCD, 8'hA0, 8'hA5);
    give_verdict();
  end
endmodule
